// File: hdl/paper_tape_defines.vh
`ifndef PAPER_TAPE_DEFINES_VH
`define PAPER_TAPE_DEFINES_VH
// register byte offsets
`define REG_CONTROL_WORD 8'h00
`define REG_WORD_COUNT 8'h04
`define REG_DATA 8'h08
`define REG_STATUS 8'h0C
`define REG_ACTIVE_TEST 8'h10
// control word fields, bit 0 is the least significant bit
`define CW_UNIT_MSB 5
`define CW_CPW_BIT 7
`define CW_LEADER_BIT 10
`define CW_ALERT_BIT 14
// unit addresses
`define UNIT_READER1 6'h04
`define UNIT_READER2 6'h05
`define UNIT_PUNCH1 6'h24
`define UNIT_PUNCH2 6'h25
// status bits
`define ST_ACTIVE 0
`define ST_DATA_VALID 1
`define ST_PUNCH_EMPTY 2
`define ST_EOR 3
`define ST_PARITY_ERR 4
`define ST_PUNCH_MOTOR 5
`define ST_ALERT 6
`define ST_UNIT2 7
`define ST_IS_PUNCH 8
`define ST_READY 9
// frame layout
`define FRAME_PARITY_BIT 6
// reset values
`define RST_WORD 24'h000000
`define RST_COUNT 14'h0000
// timing
`define CLK_PERIOD_NS 10
`define PUNCH_CHAR_NS 16666667
// one sixtieth of a second in clock cycles, rounded up
`define PUNCH_CHAR_CYCLES 21'h196E6B
`define LEADER_FRAMES 4'hC
`endif

// File: hdl/paper_tape_io_control.v
// Added by the designer: the register addresses and the AHB-Lite slave port.
`timescale 1ns/10ps
`include "paper_tape_defines.vh"
module paper_tape_io_control #(
   parameter [20:0] PUNCH_CYCLES = `PUNCH_CHAR_CYCLES
) (
   input wire core_clk_i,
   input wire reset_i,
   input wire hsel_i,
   input wire [31:0] haddr_i,
   input wire [1:0] htrans_i,
   input wire hwrite_i,
   input wire [2:0] hsize_i,
   input wire [31:0] hwdata_i,
   input wire hready_i,
   output reg [31:0] hrdata_o,
   output reg hreadyout_o,
   output reg hresp_o,
   input wire [7:0] reader_frame_i,
   input wire reader_sprocket_i,
   output reg reader_motor_o,
   output reg reader_unit2_o,
   output reg [7:0] punch_frame_o,
   output reg punch_strobe_o,
   output reg punch_motor_o,
   output reg punch_unit2_o
);
   localparam [4:0] S_IDLE = 5'h01;
   localparam [4:0] S_READ = 5'h02;
   localparam [4:0] S_LEADER = 5'h04;
   localparam [4:0] S_PWAIT = 5'h08;
   localparam [4:0] S_PUNCH = 5'h10;

   reg [4:0] state;
   reg [23:0] control_word;
   reg [13:0] word_count;
   reg [23:0] read_word;
   reg [23:0] punch_buf;
   reg [23:0] punch_shift;
   reg data_valid;
   reg punch_full;
   reg eor_flag;
   reg parity_err;
   reg four_cpw;
   reg seen_data;
   reg [1:0] char_idx;
   reg [3:0] leader_left;
   reg [20:0] pace;
   reg [8:0] sync1;
   reg [8:0] sync2;
   reg sprocket_d;
   reg dp_write;
   reg [7:0] dp_addr;
   reg next_motor;

   wire addr_phase;
   wire frame_strobe;
   wire [6:0] frame_bits;
   wire frame_blank;
   wire wr_control;
   wire wr_count;
   wire wr_data;
   wire wr_status;
   wire rd_pop;
   wire [5:0] unit;
   wire pace_done;
   wire [6:0] punch_char;
   wire [9:0] status_bits;
   wire active;
   wire gap_frame;
   wire word_full;
   wire parity_bad;
   wire punch_take;
   wire word_size;

   assign addr_phase = hsel_i & hready_i & htrans_i[1];
   assign wr_control = dp_write & (dp_addr == `REG_CONTROL_WORD);
   assign wr_count = dp_write & (dp_addr == `REG_WORD_COUNT);
   assign wr_data = dp_write & (dp_addr == `REG_DATA);
   assign wr_status = dp_write & (dp_addr == `REG_STATUS);
   assign rd_pop = addr_phase & ~hwrite_i & (haddr_i[7:0] == `REG_DATA);
   assign unit = hwdata_i[`CW_UNIT_MSB:0];
   assign active = ~state[0];
   assign pace_done = (pace == 21'h000000);

   // reader frame decode from synchronised pins
   assign frame_strobe = sync2[8] & ~sprocket_d;
   assign frame_bits = sync2[6:0];
   assign frame_blank = (frame_bits == 7'h00);

   assign punch_char = {~(^punch_shift[23:18]), punch_shift[23:18]};

   assign status_bits = {1'b1, ~state[1] & active, control_word[0], control_word[`CW_ALERT_BIT],
                         punch_motor_o, parity_err, eor_flag, ~punch_full, data_valid, active};

   // blank frame taken after data ends the block
   assign gap_frame = reader_motor_o & frame_strobe & frame_blank & seen_data;

   // a word is complete after four characters, or after one
   assign word_full = ~four_cpw | (char_idx == 2'h3);

   // even hole count on a data frame is a parity fault
   assign parity_bad = reader_motor_o & frame_strobe & ~frame_blank & ~(^frame_bits);

   // punch takes a word only once it is both counted and buffered
   assign punch_take = state[3] & ~wr_control & punch_full & (word_count != `RST_COUNT);

   // only whole-word writes reach the registers
   assign word_size = (hsize_i == 3'h2);

   // two-stage synchroniser on tape reader pins, then edge register
   always @(posedge core_clk_i) begin
      if (reset_i) begin
         sync1 <= 9'h000;
         sync2 <= 9'h000;
         sprocket_d <= 1'b0;
      end else begin
         sync1 <= {reader_sprocket_i, reader_frame_i};
         sync2 <= sync1;
         sprocket_d <= sync2[8];
      end
   end

   // bus data phase capture; zero wait states, always okay
   always @(posedge core_clk_i) begin
      if (reset_i) begin
         dp_write <= 1'b0;
         dp_addr <= 8'h00;
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end else begin
         dp_write <= addr_phase & hwrite_i & word_size;
         dp_addr <= haddr_i[7:0];
         hreadyout_o <= 1'b1;
         hresp_o <= 1'b0;
      end
   end

   // read data prepared during address phase; unmapped reads zero
   always @(posedge core_clk_i) begin
      if (reset_i) begin
         hrdata_o <= 32'h00000000;
      end else if (addr_phase & ~hwrite_i) begin
         case (haddr_i[7:0])
            `REG_CONTROL_WORD: hrdata_o <= {8'h00, control_word};
            `REG_WORD_COUNT: hrdata_o <= {18'h00000, word_count};
            `REG_DATA: hrdata_o <= {8'h00, read_word};
            `REG_STATUS: hrdata_o <= {22'h000000, status_bits};
            // bit set means execute next, clear means skip
            `REG_ACTIVE_TEST: hrdata_o <= {31'h00000000, active};
            default: hrdata_o <= 32'h00000000;
         endcase
      end
   end

   // sticky flags: hardware set wins over software clear
   always @(posedge core_clk_i) begin
      if (reset_i) begin
         eor_flag <= 1'b0;
         parity_err <= 1'b0;
      end else begin
         if (state[1] & gap_frame) begin
            eor_flag <= 1'b1;
         end else if (wr_status & hwdata_i[`ST_EOR]) begin
            eor_flag <= 1'b0;
         end
         if (state[1] & parity_bad) begin
            parity_err <= 1'b1;
         end else if (wr_status & hwdata_i[`ST_PARITY_ERR]) begin
            parity_err <= 1'b0;
         end
      end
   end

   // punch buffer filled by software, emptied by the punch sequencer
   always @(posedge core_clk_i) begin
      if (reset_i) begin
         punch_buf <= `RST_WORD;
         punch_full <= 1'b0;
      end else begin
         if (wr_data) begin
            punch_buf <= hwdata_i[23:0];
         end
         if (wr_data) begin
            punch_full <= 1'b1;
         end else if (punch_take | wr_control) begin // a new command drops a stale word
            punch_full <= 1'b0;
         end
      end
   end

   // motor enable for the reader: runs only while a word can be taken
   always @* begin
      // halt between frames at zero count
      next_motor = state[1] & (word_count != `RST_COUNT) & ~data_valid;
      // halt right after first gap frame
      if (gap_frame) begin
         next_motor = 1'b0;
      end
   end

   // main sequencer
   always @(posedge core_clk_i) begin
      if (reset_i) begin
         state <= S_IDLE;
         control_word <= `RST_WORD;
         word_count <= `RST_COUNT;
         read_word <= `RST_WORD;
         punch_shift <= `RST_WORD;
         data_valid <= 1'b0;
         four_cpw <= 1'b0;
         seen_data <= 1'b0;
         char_idx <= 2'h0;
         leader_left <= 4'h0;
         pace <= 21'h000000;
         reader_motor_o <= 1'b0;
         reader_unit2_o <= 1'b0;
         punch_frame_o <= 8'h00;
         punch_strobe_o <= 1'b0;
         punch_motor_o <= 1'b0;
         punch_unit2_o <= 1'b0;
      end else begin
         punch_strobe_o <= 1'b0;
         reader_motor_o <= next_motor;
         if (~pace_done) begin
            pace <= pace - 21'h000001;
         end
         if (rd_pop) begin
            data_valid <= 1'b0;
         end
         // control word starts an operation on the addressed unit
         if (wr_control) begin
            control_word <= hwdata_i[23:0];
            four_cpw <= hwdata_i[`CW_CPW_BIT];
            char_idx <= 2'h0;
            seen_data <= 1'b0;
            read_word <= `RST_WORD;
            data_valid <= 1'b0;
            if ((unit == `UNIT_READER1) | (unit == `UNIT_READER2)) begin
               state <= S_READ;
               reader_unit2_o <= unit[0];
            end else if ((unit == `UNIT_PUNCH1) | (unit == `UNIT_PUNCH2)) begin
               punch_motor_o <= 1'b1;
               punch_unit2_o <= unit[0];
               if (~hwdata_i[`CW_LEADER_BIT]) begin
                  state <= S_LEADER;
                  leader_left <= `LEADER_FRAMES;
               end else begin
                  state <= S_PWAIT;
               end
            end
         end else begin
            case (state)
               S_IDLE: begin
                  state <= S_IDLE;
               end
               S_READ: begin
                  if (reader_motor_o & frame_strobe) begin
                     if (frame_blank) begin
                        if (seen_data) begin
                           // partial word delivered at the gap
                           if (char_idx != 2'h0) begin
                              data_valid <= 1'b1;
                              word_count <= word_count - 14'h0001;
                           end
                           state <= S_IDLE;
                        end
                     end else begin
                        seen_data <= 1'b1;
                        read_word <= (char_idx == 2'h0) ? {18'h00000, frame_bits[5:0]} :
                                     {read_word[17:0], frame_bits[5:0]};
                        if (word_full) begin
                           char_idx <= 2'h0;
                           data_valid <= 1'b1;
                           word_count <= word_count - 14'h0001;
                           if (word_count == 14'h0001) begin
                              state <= S_IDLE;
                           end
                        end else begin
                           char_idx <= char_idx + 2'h1;
                        end
                     end
                  end
               end
               S_LEADER: begin
                  if (pace_done) begin
                     punch_frame_o <= 8'h00;
                     punch_strobe_o <= 1'b1;
                     pace <= PUNCH_CYCLES - 21'h000001;
                     leader_left <= leader_left - 4'h1;
                     if (leader_left == 4'h1) begin
                        state <= S_PWAIT;
                     end
                  end
               end
               S_PWAIT: begin
                  if (seen_data & (word_count == `RST_COUNT)) begin
                     state <= S_IDLE;
                  end else if (punch_take) begin
                     seen_data <= 1'b1; // count now given, so zero later means done
                     punch_shift <= punch_buf;
                     if (~four_cpw) begin
                        punch_shift <= {punch_buf[5:0], 18'h00000};
                     end
                     word_count <= word_count - 14'h0001;
                     char_idx <= 2'h0;
                     state <= S_PUNCH;
                  end
               end
               S_PUNCH: begin
                  if (pace_done) begin
                     punch_frame_o <= {1'b0, punch_char};
                     punch_strobe_o <= 1'b1;
                     pace <= PUNCH_CYCLES - 21'h000001;
                     punch_shift <= {punch_shift[17:0], 6'h00};
                     char_idx <= char_idx + 2'h1;
                     if (word_full) begin
                        state <= S_PWAIT;
                     end
                  end
               end
               default: begin
                  state <= S_IDLE;
               end
            endcase
         end
         // software count load wins over a decrement in the same cycle
         if (wr_count) begin
            word_count <= hwdata_i[13:0];
         end
      end
   end
endmodule

// File: verification/paper_tape_checker.sv
`timescale 1ns/10ps
module paper_tape_checker #(
   parameter [20:0] PUNCH_CYCLES = 21'h000014
) (
   input wire core_clk_i,
   input wire reset_i,
   input wire hsel_i,
   input wire [31:0] haddr_i,
   input wire [1:0] htrans_i,
   input wire hwrite_i,
   input wire hready_i,
   input wire [31:0] hrdata_o,
   input wire hreadyout_o,
   input wire hresp_o,
   input wire [7:0] punch_frame_o,
   input wire punch_strobe_o,
   input wire punch_motor_o
);
   default clocking dc @(posedge core_clk_i); endclocking
   default disable iff (reset_i);
   reg [21:0] gap;
   reg seen;
   wire rd_phase = hsel_i && hready_i && htrans_i[1] && !hwrite_i;
   // cycles since the last punch strobe, saturating
   always @(posedge core_clk_i) begin
      if (reset_i) begin
         gap <= 22'h000000;
         seen <= 1'b0;
      end else if (punch_strobe_o) begin
         gap <= 22'h000001;
         seen <= 1'b1;
      end else if (gap != 22'h3FFFFF) begin
         gap <= gap + 22'h000001;
      end
   end
   chk_ready_always: assert property (hreadyout_o)
      else $error("slave not ready");
   chk_resp_okay: assert property (!hresp_o)
      else $error("error response");
   chk_frame_parity: assert property (punch_strobe_o |-> !punch_frame_o[7] && (punch_frame_o == 8'h00 || ^punch_frame_o[6:0]))
      else $error("punched frame parity wrong");
   chk_punch_pace: assert property (seen && punch_strobe_o |-> gap >= PUNCH_CYCLES)
      else $error("punch faster than its rate");
   chk_motor_held: assert property ($rose(punch_motor_o) |=> punch_motor_o [*8])
      else $error("punch motor dropped");
   chk_motor_sticky: assert property (punch_motor_o |=> punch_motor_o)
      else $error("punch motor cleared");
   chk_strobe_motor: assert property (punch_strobe_o |-> punch_motor_o)
      else $error("punch strobe without motor");
   chk_test_width: assert property (rd_phase && haddr_i[7:0] == 8'h10 |=> hrdata_o[31:1] == 31'h00000000)
      else $error("activity test has extra bits");
   chk_status_ready: assert property (rd_phase && haddr_i[7:0] == 8'h0C |=> hrdata_o[9])
      else $error("status not ready");
   cover property (punch_strobe_o && punch_frame_o == 8'h00);
   cover property (punch_strobe_o && punch_frame_o != 8'h00);
   cover property (rd_phase && haddr_i[7:0] == 8'h08);
endmodule

// File: verification/tape_station_model.sv
`timescale 1ns/10ps
module tape_station_model (
   input wire core_clk_i,
   input wire motor_i,
   input wire [7:0] pframe_i,
   input wire pstrobe_i,
   output logic [7:0] frame_o,
   output logic sprocket_o
);
   logic [7:0] tape [0:15];
   logic [7:0] got [$];
   int pos = 0;
   int len = 0;
   // one frame per pass while the motor runs, holes inverted between frames
   initial begin
      frame_o = 8'h00;
      sprocket_o = 1'b0;
      forever begin
         @(posedge core_clk_i);
         if (motor_i === 1'b1 && pos < len) begin
            frame_o <= tape[pos];
            repeat (2) @(posedge core_clk_i);
            sprocket_o <= 1'b1;
            repeat (4) @(posedge core_clk_i);
            sprocket_o <= 1'b0;
            repeat (2) @(posedge core_clk_i);
            frame_o <= ~tape[pos];
            pos = pos + 1;
         end
      end
   end
   // keep every punched frame
   always @(posedge core_clk_i) begin
      if (pstrobe_i === 1'b1) got.push_back(pframe_i);
   end
endmodule

// File: verification/paper_tape_io_control_tb.sv
`timescale 1ns/10ps
module paper_tape_io_control_tb;
   localparam [20:0] PUNCH_CYCLES = 21'h000014;
   logic core_clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h00000000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h00000000;
   wire [31:0] hrdata;
   wire hreadyout, hresp, r_motor, r_unit2, p_strobe, p_motor, p_unit2, sprocket;
   wire [7:0] p_frame, t_frame;
   int n_fail = 0;
   int checks_done = 0;
   logic [31:0] rd;
   logic [5:0] ch [0:4] = '{6'h15, 6'h2A, 6'h3F, 6'h01, 6'h22};
   always #5 core_clk_i = ~core_clk_i;
   paper_tape_io_control #(.PUNCH_CYCLES(PUNCH_CYCLES)) DUT (.core_clk_i(core_clk_i), .reset_i(reset_i),
      .hsel_i(hsel), .haddr_i(haddr), .htrans_i(htrans), .hwrite_i(hwrite), .hsize_i(3'h2),
      .hwdata_i(hwdata), .hready_i(hreadyout), .hrdata_o(hrdata), .hreadyout_o(hreadyout), .hresp_o(hresp),
      .reader_frame_i(t_frame), .reader_sprocket_i(sprocket), .reader_motor_o(r_motor),
      .reader_unit2_o(r_unit2), .punch_frame_o(p_frame), .punch_strobe_o(p_strobe),
      .punch_motor_o(p_motor), .punch_unit2_o(p_unit2));
   tape_station_model st (.core_clk_i(core_clk_i), .motor_i(r_motor), .pframe_i(p_frame),
      .pstrobe_i(p_strobe), .frame_o(t_frame), .sprocket_o(sprocket));
   function automatic logic [7:0] fr(input logic [5:0] c);
      fr = {1'b0, ~^c, c};
   endfunction
   // verdict and end of run
   task automatic wrap_up;
      $display("checks %0d mismatches %0d", checks_done, n_fail);
      if (n_fail == 0 && checks_done > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
      checks_done++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask
   task automatic wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (hreadyout !== 1'b1) begin
         $display("mismatch at %0t: bus answer timed out", $time);
         n_fail++;
         wrap_up();
      end
   endtask
   // one single word transfer, address phase then data phase
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      @(posedge core_clk_i);
      hsel <= 1'b1;
      haddr <= {24'h000000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      wait_rdy();
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= wd;
      wait_rdy();
      rd = hrdata;
   endtask
   task automatic poll(input logic [7:0] a, input logic [31:0] m, input logic [31:0] v);
      int n;
      n = 0;
      do begin
         bus(1'b0, a, 32'h00000000);
         n++;
      end while ((rd & m) !== v && n < 500);
      if ((rd & m) !== v) begin
         $display("mismatch at %0t: status poll timed out", $time);
         n_fail++;
         wrap_up();
      end
   endtask
   task automatic frames(input int n);
      int k;
      k = 0;
      while (st.got.size() < n && k < 5000) begin
         @(posedge core_clk_i);
         k++;
      end
      if (st.got.size() < n) begin
         $display("mismatch at %0t: punch frames timed out", $time);
         n_fail++;
         wrap_up();
      end
   endtask
   // overall guard against a hang
   initial begin
      repeat (100000) @(posedge core_clk_i);
      $display("mismatch at %0t: run limit reached", $time);
      n_fail++;
      wrap_up();
   end
   initial begin
      for (int i = 0; i < 9; i++) st.tape[i] = 8'h00;
      for (int i = 0; i < 5; i++) st.tape[i + 2] = fr(ch[i]);
      st.tape[6] = {1'b0, ^ch[4], ch[4]};
      st.tape[8] = fr(ch[0]);
      st.len = 9;
      repeat (8) @(posedge core_clk_i);
      reset_i <= 1'b0;
      bus(1'b1, 8'h00, 32'h00010584);
      bus(1'b1, 8'h04, 32'h00000001);
      poll(8'h0C, 32'h00000002, 32'h00000002);
      bus(1'b0, 8'h10, 32'h00000000);
      cmp(rd, 32'h00000000, "channel inactive at zero count");
      repeat (20) @(posedge core_clk_i);
      cmp(st.pos, 6, "reader stop point");
      cmp(r_motor, 32'h00000000, "reader halted");
      cmp(r_unit2, 32'h00000000, "reader one selected");
      bus(1'b0, 8'h08, 32'h00000000);
      cmp(rd, {8'h00, ch[0], ch[1], ch[2], ch[3]}, "word after leading blanks");
      $display("test reader count stop done");
      bus(1'b1, 8'h00, 32'h00010584);
      bus(1'b1, 8'h04, 32'h00000002);
      poll(8'h0C, 32'h00000008, 32'h00000008);
      repeat (20) @(posedge core_clk_i);
      cmp(st.pos, 8, "stop after first gap frame");
      bus(1'b0, 8'h0C, 32'h00000000);
      cmp(rd & 32'h00000018, 32'h00000018, "gap and parity flags");
      bus(1'b0, 8'h08, 32'h00000000);
      cmp(rd, {26'h0000000, ch[4]}, "partial word at gap");
      bus(1'b1, 8'h0C, 32'h00000018);
      bus(1'b0, 8'h0C, 32'h00000000);
      cmp(rd & 32'h00000218, 32'h00000200, "flags cleared, ready");
      bus(1'b0, 8'h20, 32'h00000000);
      cmp(rd, 32'h00000000, "unmapped read");
      $display("test reader gap done");
      bus(1'b1, 8'h00, 32'h000101A4);
      @(negedge core_clk_i);
      cmp(p_motor, 32'h00000001, "punch motor on");
      frames(12);
      for (int i = 0; i < 12; i++) cmp(st.got[i], 32'h00000000, "leader frame");
      bus(1'b1, 8'h04, 32'h00000002);
      bus(1'b1, 8'h08, {8'h00, ch[0], ch[1], ch[2], ch[3]});
      frames(16);
      repeat (150) @(posedge core_clk_i);
      bus(1'b1, 8'h08, {8'h00, ch[4], ch[3], ch[2], ch[1]});
      frames(20);
      repeat (200) @(posedge core_clk_i);
      cmp(st.got.size(), 20, "no trailing gap");
      for (int i = 0; i < 4; i++) cmp(st.got[12 + i], fr(ch[i]), "first word frame");
      for (int i = 0; i < 4; i++) cmp(st.got[16 + i], fr(ch[4 - i]), "late word frame");
      $display("test punch leader done");
      bus(1'b1, 8'h00, 32'h000105A4);
      bus(1'b1, 8'h04, 32'h00000001);
      bus(1'b1, 8'h08, {8'h00, ch[3], ch[2], ch[1], ch[0]});
      frames(24);
      cmp(st.got[20], fr(ch[3]), "no leader, data first");
      bus(1'b1, 8'h00, 32'h00014525);
      @(negedge core_clk_i);
      cmp(p_unit2, 32'h00000001, "punch two selected");
      bus(1'b1, 8'h04, 32'h00000001);
      bus(1'b1, 8'h08, 32'h0000002A);
      frames(25);
      repeat (100) @(posedge core_clk_i);
      cmp(st.got.size(), 25, "one character a word");
      cmp(st.got[24], fr(6'h2A), "single frame");
      bus(1'b0, 8'h0C, 32'h00000000);
      cmp(rd & 32'h000000E0, 32'h000000E0, "alert, unit two, motor");
      bus(1'b1, 8'h00, 32'h00010585);
      @(negedge core_clk_i);
      cmp(r_unit2, 32'h00000001, "reader two selected");
      bus(1'b0, 8'h10, 32'h00000000);
      cmp(rd, 32'h00000001, "channel active");
      $display("test punch no leader done");
      wrap_up();
   end
endmodule
bind paper_tape_io_control paper_tape_checker #(.PUNCH_CYCLES(PUNCH_CYCLES)) chk (.core_clk_i(core_clk_i),
   .reset_i(reset_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i), .hwrite_i(hwrite_i),
   .hready_i(hready_i), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o), .hresp_o(hresp_o),
   .punch_frame_o(punch_frame_o), .punch_strobe_o(punch_strobe_o), .punch_motor_o(punch_motor_o));
